/* File: branch_record_defs.vh */
/*
  Constants for the branch record ring: register addresses, field positions,
  reset values, format codes and ring depths.
  Assumes it is included by its bare name from the design files.
*/
`ifndef BRANCH_RECORD_DEFS_VH
`define BRANCH_RECORD_DEFS_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define REG_DEBUG_CTL 12'h1d9
`define REG_GLOBAL_STATUS 12'h38e
`define REG_GLOBAL_OVF_CLEAR 12'h390
`define REG_PERF_CAP 12'h345
`define REG_TOS 12'h1c9
`define REG_EXC_FROM 12'h1dd
`define REG_EXC_TO 12'h1de
`define REG_SRC_BASE 12'h680
`define REG_TGT_BASE 12'h6c0
`define REG_INFO_BASE 12'hdc0
`define RING_ADDR_MASK 12'hfe0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DBG_ENABLE_BIT 0
`define DBG_FREEZE_BIT 11
`define STAT_FROZEN_BIT 58
`define ADDR_MSB 47
`define SIGN_FILL_LSB 48
`define SIGN_FILL_WIDTH 13
`define ABORT_BIT 61
`define IN_TRANS_BIT 62
`define MISPREDICT_BIT 63
`define CAP_FORMAT_WIDTH 6

// ----------------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------------
`define DEBUG_CTL_RESET 64'h0000000000000000
`define DEBUG_CTL_WR_MASK 64'h0000000000000801
`define FMT_LEGACY 6'h04
`define FMT_NEWER 6'h05
`define TOS_LEGACY_MASK 5'h0f
`define TOS_NEWER_MASK 5'h1f
`define STREAMLINE_MIN_VERSION 8'h04
`define SHALLOW_SLEEP_MAX 4'h1
`define CYCLE_COUNT_WIDTH 16
`define RING_SLOTS 32

`endif

/* File: branch_record_properties.sv */
/* Port checker for the branch record ring.
   Bound onto branch_record_stack_ext; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module branch_record_properties (
  input wire logic sys_clk, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic newer_gen, // Format select
  input wire logic [7:0] perf_mon_version, // Monitoring version
  input wire logic sample_buffer_full, // Buffer full pulse
  input wire logic sleep_enter, // Wait state pulse
  input wire logic msr_rd, // Read request
  input wire logic msr_wr, // Write request
  input wire logic [11:0] msr_addr, // Address
  input wire logic [63:0] msr_wdata, // Write data
  input wire logic [63:0] msr_rdata, // Read data
  input wire logic ring_frozen_status, // Frozen flag
  input wire logic recording_active // Ring accepting
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cap_rd;
    msr_rd && msr_addr == 12'h345;
  endsequence
  sequence s_release_wr;
    msr_wr && msr_addr == 12'h390 && msr_wdata[58] && !sample_buffer_full;
  endsequence
  sequence s_quiet_sleep;
    sleep_enter && !sample_buffer_full && !msr_wr;
  endsequence
  a_cap_format: assert property (s_cap_rd |=>
    msr_rdata[5:0] == (newer_gen ? 6'h05 : 6'h04)) else $error("capability format wrong");
  a_frozen_cause: assert property ($rose(ring_frozen_status) |->
    $past(sample_buffer_full) && perf_mon_version >= 8'h04) else $error("frozen without cause");
  a_release_clears: assert property (s_release_wr |=> !ring_frozen_status)
    else $error("frozen flag not released");
  a_hold_frozen: assert property (ring_frozen_status && !msr_wr |=> ring_frozen_status)
    else $error("frozen flag dropped");
  a_legacy_no_flag: assert property (perf_mon_version < 8'h04 |-> !ring_frozen_status)
    else $error("legacy scheme set frozen flag");
  a_stop_cause: assert property ($fell(recording_active) |->
    $past(sample_buffer_full || msr_wr)) else $error("recording stopped without cause");
  a_frozen_blocks: assert property (ring_frozen_status |-> !recording_active)
    else $error("recording while frozen");
  a_sleep_flag: assert property (s_quiet_sleep |=> $stable(ring_frozen_status))
    else $error("sleep changed frozen flag");
  a_sleep_enable: assert property (s_quiet_sleep |=> $stable(recording_active))
    else $error("sleep changed enable");
endmodule // branch_record_properties
bind branch_record_stack_ext branch_record_properties chk_u (.sys_clk, .rst_n, .newer_gen,
  .perf_mon_version, .sample_buffer_full, .sleep_enter, .msr_rd, .msr_wr, .msr_addr,
  .msr_wdata, .msr_rdata, .ring_frozen_status, .recording_active);
`default_nettype wire

/* File: branch_record_stack_ext.v */
/*
  Branch record ring with source, target and info entries, freeze on
  sample buffer full (legacy and streamlined), and deep sleep clearing.
  Assumes the retirement logic presents one record per cycle at most, that
  newer_gen and perf_mon_version are static while recording, and that
  register requests are one-cycle pulses, one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "branch_record_defs.vh"

module branch_record_stack_ext (
  input wire sys_clk,               // Core clock, 100 MHz
  input wire rst_n,                 // Async reset, active low
  input wire newer_gen,             // 1: 32-entry triplet format
  input wire [7:0] perf_mon_version, // Monitoring version
  input wire br_valid,              // Retired branch, one-cycle pulse
  input wire [47:0] br_from,        // Branch source address
  input wire [63:0] br_to,          // Branch target entry value
  input wire br_abort,              // Record is a transactional abort
  input wire br_in_trans,           // Branch inside transactional region
  input wire br_mispredict,         // Target or direction mispredicted
  input wire br_exception,          // Record is an exception or interrupt
  input wire sample_buffer_full,    // Sample buffer became full, pulse
  input wire sleep_enter,           // Wait state entered, pulse
  input wire [3:0] sleep_depth,     // Requested wait state number
  input wire sleep_clears,          // Chosen wait state loses ring state
  input wire msr_rd,                // Register read request, pulse
  input wire msr_wr,                // Register write request, pulse
  input wire [11:0] msr_addr,       // Register address
  input wire [63:0] msr_wdata,      // Register write data
  output reg msr_ack,               // Request done, pulse
  output reg msr_fault,             // Request refused, pulse with ack
  output reg [63:0] msr_rdata,      // Read data, valid with ack
  output wire ring_frozen_status,   // Frozen flag level
  output wire recording_active      // Ring accepting records
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [63:0] debug_control_reg;
  reg ring_frozen_flag;
  reg [4:0] top_of_stack_pointer;
  reg after_clear;
  reg [63:0] src_mem [0:`RING_SLOTS-1];
  reg [63:0] tgt_mem [0:`RING_SLOTS-1];
  reg [63:0] info_mem [0:`RING_SLOTS-1];
  reg [63:0] exc_from;
  reg [63:0] exc_to;
  reg [63:0] next_debug_control;
  reg next_frozen;
  reg [63:0] rd_value;
  reg rd_hit;
  reg wr_hit;
  integer i;

  wire [`CYCLE_COUNT_WIDTH-1:0] elapsed;
  wire streamlined;
  wire freeze_event;
  wire deep_clear;
  wire record_ok;
  wire [4:0] tos_mask;
  wire [4:0] next_tos;
  wire [63:0] src_word;
  wire [63:0] info_word;
  wire [5:0] cap_format;
  wire [4:0] rd_index;
  wire index_ok;

  // --------------------------------------------------------------------------
  // Record path
  // --------------------------------------------------------------------------
  assign streamlined = (perf_mon_version >= `STREAMLINE_MIN_VERSION);
  assign freeze_event = sample_buffer_full & debug_control_reg[`DBG_FREEZE_BIT];
  assign deep_clear = sleep_enter & sleep_clears & (sleep_depth > `SHALLOW_SLEEP_MAX);
  assign record_ok = br_valid & debug_control_reg[`DBG_ENABLE_BIT]
                     & ~ring_frozen_flag & ~deep_clear;
  assign tos_mask = newer_gen ? `TOS_NEWER_MASK : `TOS_LEGACY_MASK;
  assign next_tos = (top_of_stack_pointer + 5'h01) & tos_mask;
  assign ring_frozen_status = ring_frozen_flag;
  assign recording_active = debug_control_reg[`DBG_ENABLE_BIT] & ~ring_frozen_flag;

  // Older format carries flags in the source entry, newer in the info entry
  assign src_word[`ADDR_MSB:0] = br_from;
  assign src_word[`ABORT_BIT-1:`SIGN_FILL_LSB] = {`SIGN_FILL_WIDTH{br_from[`ADDR_MSB]}};
  assign src_word[`ABORT_BIT] = ~newer_gen & br_abort;
  assign src_word[`IN_TRANS_BIT] = ~newer_gen & br_in_trans;
  assign src_word[`MISPREDICT_BIT] = ~newer_gen & br_mispredict;

  assign info_word[`CYCLE_COUNT_WIDTH-1:0] = after_clear ? {`CYCLE_COUNT_WIDTH{1'b0}}
                                                         : elapsed;
  assign info_word[`ABORT_BIT-1:`CYCLE_COUNT_WIDTH] = {(`ABORT_BIT-`CYCLE_COUNT_WIDTH){1'b0}};
  assign info_word[`ABORT_BIT] = br_abort;
  assign info_word[`IN_TRANS_BIT] = br_in_trans;
  assign info_word[`MISPREDICT_BIT] = br_mispredict;

  assign cap_format = newer_gen ? `FMT_NEWER : `FMT_LEGACY;

  sat_counter #(
    .WIDTH(`CYCLE_COUNT_WIDTH)
  ) u_elapsed (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(record_ok | deep_clear),
    .count(elapsed)
  );

  // --------------------------------------------------------------------------
  // Control register updates
  // --------------------------------------------------------------------------
  always @* begin
    next_debug_control = debug_control_reg;
    next_frozen = ring_frozen_flag;
    if (msr_wr && msr_addr == `REG_DEBUG_CTL) begin
      next_debug_control = msr_wdata & `DEBUG_CTL_WR_MASK;
    end
    if (msr_wr && msr_addr == `REG_GLOBAL_OVF_CLEAR && msr_wdata[`STAT_FROZEN_BIT]) begin
      next_frozen = 1'b0;
    end
    // Freeze applied last so it wins over a same-cycle write
    if (freeze_event && !streamlined) begin
      next_debug_control[`DBG_ENABLE_BIT] = 1'b0;
    end
    if (freeze_event && streamlined) begin
      next_frozen = 1'b1;
    end
  end

  // Deep sleep leaves both of these alone
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_control_reg <= `DEBUG_CTL_RESET;
      ring_frozen_flag <= 1'b0;
    end else begin
      debug_control_reg <= next_debug_control;
      ring_frozen_flag <= next_frozen;
    end
  end

  // --------------------------------------------------------------------------
  // Ring storage
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      top_of_stack_pointer <= 5'h00;
      after_clear <= 1'b0;
      exc_from <= 64'h0000000000000000;
      exc_to <= 64'h0000000000000000;
      for (i = 0; i < `RING_SLOTS; i = i + 1) begin
        src_mem[i] <= 64'h0000000000000000;
        tgt_mem[i] <= 64'h0000000000000000;
        info_mem[i] <= 64'h0000000000000000;
      end
    end else if (deep_clear) begin
      top_of_stack_pointer <= 5'h00;
      after_clear <= 1'b1;
      exc_from <= 64'h0000000000000000;
      exc_to <= 64'h0000000000000000;
      for (i = 0; i < `RING_SLOTS; i = i + 1) begin
        src_mem[i] <= 64'h0000000000000000;
        tgt_mem[i] <= 64'h0000000000000000;
        info_mem[i] <= 64'h0000000000000000;
      end
    end else if (record_ok) begin
      top_of_stack_pointer <= next_tos;
      after_clear <= 1'b0;
      src_mem[next_tos] <= src_word;
      tgt_mem[next_tos] <= br_to;
      info_mem[next_tos] <= newer_gen ? info_word : 64'h0000000000000000;
      if (br_exception) begin
        exc_from <= src_word;
        exc_to <= br_to;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register read decode
  // --------------------------------------------------------------------------
  assign rd_index = msr_addr[4:0];
  assign index_ok = newer_gen | ~msr_addr[4];

  always @* begin
    rd_value = 64'h0000000000000000;
    rd_hit = 1'b1;
    case (msr_addr)
      `REG_DEBUG_CTL: begin
        rd_value = debug_control_reg;
      end
      `REG_GLOBAL_STATUS: begin
        rd_value[`STAT_FROZEN_BIT] = ring_frozen_flag;
      end
      `REG_PERF_CAP: begin
        rd_value[`CAP_FORMAT_WIDTH-1:0] = cap_format;
      end
      `REG_TOS: begin
        rd_value[4:0] = top_of_stack_pointer;
      end
      `REG_EXC_FROM: begin
        rd_value = exc_from;
      end
      `REG_EXC_TO: begin
        rd_value = exc_to;
      end
      default: begin
        if ((msr_addr & `RING_ADDR_MASK) == `REG_SRC_BASE && index_ok) begin
          rd_value = src_mem[rd_index];
        end else if ((msr_addr & `RING_ADDR_MASK) == `REG_TGT_BASE && index_ok) begin
          rd_value = tgt_mem[rd_index];
        end else if ((msr_addr & `RING_ADDR_MASK) == `REG_INFO_BASE && newer_gen) begin
          rd_value = info_mem[rd_index];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // Only control and clear registers take writes
  always @* begin
    case (msr_addr)
      `REG_DEBUG_CTL: begin
        wr_hit = 1'b1;
      end
      `REG_GLOBAL_OVF_CLEAR: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Register answer
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      msr_ack <= 1'b0;
      msr_fault <= 1'b0;
      msr_rdata <= 64'h0000000000000000;
    end else begin
      msr_ack <= msr_rd | msr_wr;
      msr_fault <= (msr_rd & ~rd_hit) | (msr_wr & ~wr_hit);
      if (msr_rd && rd_hit) begin
        msr_rdata <= rd_value;
      end else if (msr_rd || msr_wr) begin
        msr_rdata <= 64'h0000000000000000;
      end
    end
  end

endmodule // branch_record_stack_ext

`default_nettype wire

/* File: branch_retire_model.sv */
/* Retirement side model: hands one branch record per call.
   Assumes the caller runs from the bench's main process. */
`timescale 1ns/1ps
`default_nettype none
module branch_retire_model (
  input wire logic sys_clk, // Core clock
  output logic br_valid, // Record strobe
  output logic [47:0] br_from, // Source address
  output logic [63:0] br_to, // Target entry
  output logic br_abort, // Abort record
  output logic br_in_trans, // Inside region
  output logic br_mispredict, // Mispredicted
  output logic br_exception // Exception record
);
  initial begin
    br_valid = 1'b0;
    br_from = '0;
    br_to = '0;
    {br_exception, br_abort, br_in_trans, br_mispredict} = 4'h0;
  end
  // Flags {exception, abort, in region, mispredict}; abort gives handler as target
  task send(input logic [47:0] f, input logic [63:0] t, input logic [3:0] fl);
    @(posedge sys_clk);
    br_valid <= 1'b1;
    br_from <= f;
    br_to <= t;
    {br_exception, br_abort, br_in_trans, br_mispredict} <= fl;
    @(posedge sys_clk);
    br_valid <= 1'b0;
    br_from <= ~f;
    br_to <= ~t;
    {br_exception, br_abort, br_in_trans, br_mispredict} <= ~fl;
  endtask
endmodule // branch_retire_model
`default_nettype wire

/* File: sat_counter.v */
/*
  Saturating up-counter with synchronous restart.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module sat_counter #(
  parameter WIDTH = 16
) (
  input wire sys_clk,             // Core clock
  input wire rst_n,               // Async reset, active low
  input wire restart,             // Restart from zero next cycle
  output reg [WIDTH-1:0] count    // Current count
);

  // --------------------------------------------------------------------------
  // Count and hold at all ones
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
    end else if (restart) begin
      count <= {WIDTH{1'b0}};
    end else if (count != {WIDTH{1'b1}}) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // sat_counter

`default_nettype wire

/* File: tb_branch_record_stack_ext.sv */
/* Self-checking bench for the branch record ring, both formats.
   Assumes the retirement model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_branch_record_stack_ext;
  logic sys_clk, rst_n, newer_gen, sample_buffer_full, sleep_enter, sleep_clears;
  logic msr_rd, msr_wr, msr_ack, msr_fault, ring_frozen_status, recording_active;
  logic br_valid, br_abort, br_in_trans, br_mispredict, br_exception;
  logic [7:0] perf_mon_version;
  logic [3:0] sleep_depth;
  logic [11:0] msr_addr;
  logic [47:0] br_from;
  logic [63:0] br_to, msr_wdata, msr_rdata, rv;
  logic rf;
  int fail_count, samples_checked;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  branch_retire_model retire_u (.sys_clk, .br_valid, .br_from, .br_to, .br_abort,
    .br_in_trans, .br_mispredict, .br_exception);
  branch_record_stack_ext dut_u (.sys_clk, .rst_n, .newer_gen, .perf_mon_version,
    .br_valid, .br_from, .br_to, .br_abort, .br_in_trans, .br_mispredict, .br_exception,
    .sample_buffer_full, .sleep_enter, .sleep_depth, .sleep_clears, .msr_rd, .msr_wr,
    .msr_addr, .msr_wdata, .msr_ack, .msr_fault, .msr_rdata, .ring_frozen_status,
    .recording_active);
  task check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task access(input logic w, input logic [11:0] a, input logic [63:0] d);
    @(posedge sys_clk);
    msr_rd <= !w;
    msr_wr <= w;
    msr_addr <= a;
    msr_wdata <= d;
    @(posedge sys_clk);
    msr_rd <= 1'b0;
    msr_wr <= 1'b0;
    #1 rv = msr_rdata;
    rf = msr_fault;
    check(msr_ack, 64'h1);
  endtask
  // Buffer-full pulse when s, else wait state of depth d
  task event_pulse(input logic s, input logic [3:0] d);
    @(posedge sys_clk);
    sample_buffer_full <= s;
    sleep_enter <= !s;
    sleep_depth <= d;
    @(posedge sys_clk);
    sample_buffer_full <= 1'b0;
    sleep_enter <= 1'b0;
    #1;
  endtask
  task reset_dut(input logic g, input logic [7:0] v);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    newer_gen <= g;
    perf_mon_version <= v;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  task t_legacy;
    access(0, 12'h345, 0);
    check(rv[5:0], 64'h04);
    access(0, 12'h690, 0);
    check(rf, 64'h1);
    access(1, 12'h1d9, 64'hffffffffffffffff);
    access(0, 12'h1d9, 0);
    check(rv, 64'h801);
    retire_u.send(48'h800000001234, 64'h5678, 4'b0100);
    retire_u.send(48'h000000000abc, 64'h9, 4'b0011);
    access(0, 12'h681, 0);
    check(rv, 64'h3fff800000001234);
    access(0, 12'h6c1, 0);
    check(rv, 64'h5678);
    access(0, 12'h682, 0);
    check(rv, 64'hc000000000000abc);
    repeat (14) retire_u.send(48'h1, 64'h2, 4'b1000);
    access(0, 12'h1c9, 0);
    check(rv, 64'h0);
    event_pulse(1, 0);
    access(0, 12'h1d9, 0);
    check(rv, 64'h800);
    retire_u.send(48'h1, 64'h2, 0);
    access(0, 12'h1c9, 0);
    check(rv, 64'h0);
    access(1, 12'h1d9, 64'h801);
    retire_u.send(48'h1, 64'h2, 0);
    access(0, 12'h1c9, 0);
    check(rv, 64'h1);
    $display("test legacy done");
  endtask
  task t_newer;
    access(0, 12'h345, 0);
    check(rv[5:0], 64'h05);
    access(1, 12'h1d9, 64'h801);
    retire_u.send(48'h1, 64'h2, 0);
    repeat (65540) @(posedge sys_clk);
    retire_u.send(48'h800000000000, 64'h9, 4'b0111);
    access(0, 12'h682, 0);
    check(rv, 64'h1fff800000000000);
    access(0, 12'hdc2, 0);
    check(rv, 64'he00000000000ffff);
    event_pulse(0, 4'h1);
    access(0, 12'h1c9, 0);
    check(rv, 64'h2);
    event_pulse(1, 0);
    check(ring_frozen_status, 64'h1);
    access(0, 12'h1d9, 0);
    check(rv, 64'h801);
    event_pulse(0, 4'h6);
    access(0, 12'h682, 0);
    check(rv, 64'h0);
    access(0, 12'h38e, 0);
    check(rv[58], 64'h1);
    retire_u.send(48'h1, 64'h2, 0);
    access(0, 12'h1c9, 0);
    check(rv, 64'h0);
    access(1, 12'h390, 64'h0400000000000000);
    check(ring_frozen_status, 64'h0);
    retire_u.send(48'h1, 64'h2, 0);
    access(0, 12'hdc1, 0);
    check(rv, 64'h0);
    repeat (32) retire_u.send(48'h1, 64'h2, 0);
    access(0, 12'h1c9, 0);
    check(rv, 64'h1);
    $display("test newer done");
  endtask
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #900000;
    fail_count++;
    summarize;
  end
  initial begin
    {rst_n, newer_gen, sample_buffer_full, sleep_enter, msr_rd, msr_wr} = 6'h0;
    {perf_mon_version, sleep_depth, msr_addr, msr_wdata} = '0;
    sleep_clears = 1'b1;
    reset_dut(0, 8'h03);
    t_legacy;
    reset_dut(1, 8'h04);
    t_newer;
    summarize;
  end
endmodule // tb_branch_record_stack_ext
`default_nettype wire
